// >>> gia_defs.vh
// Constants for the global interrupt aggregator
`ifndef GIA_DEFS_VH
`define GIA_DEFS_VH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define GIA_OFS_FLAGS 8'h80
`define GIA_OFS_CAUSE_HIGH 8'h83
`define GIA_OFS_TIMER_CMD 8'h84
`define GIA_OFS_PIN_LEVEL 8'h90
`define GIA_WORD_ZERO 32'h0000_0000
// ----------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------
`define GIA_NUM_CH 4
`define GIA_CODE_W 3
`define GIA_CODE_BASE 8
`define GIA_FLAGS_RSVD 4'h0
`define GIA_UPPER_RSVD 12'h000
`define GIA_MID_RSVD 4'h0
`define GIA_HIGH_RSVD 8'h00
// ----------------------------------------------------------------------
// Cause codes
// ----------------------------------------------------------------------
`define GIA_CODE_NONE 3'h0
`define GIA_CODE_RX_LINE 3'h1
`define GIA_CODE_RX_TIMEOUT 3'h2
`define GIA_CODE_TX_READY 3'h3
`define GIA_CODE_MODEM 3'h4
`define GIA_CODE_PINS 3'h6
`define GIA_CODE_TIMER 3'h7
`endif

// >>> gia_cause_encoder.v
// Per-channel priority encoder for interrupt cause codes
`timescale 1ns/1ps
module gia_cause_encoder (
   // Clock and reset
   input wire sys_clk,
   input wire rst_n,
   // Channel causes, bit 0 rx/line, 1 timeout, 2 tx, 3 modem
   input wire [3:0] uart_cause,
   // Device-wide events, only wired on channel 0
   input wire wake_pending,
   input wire pin_pending,
   input wire timer_pending,
   // Result
   output reg [2:0] cause_code_reg,
   output reg request_reg
);
`include "gia_defs.vh"
reg [2:0] cause_code_next;
always @* begin
   if (uart_cause[0]) begin
      cause_code_next = `GIA_CODE_RX_LINE;
   end else if (uart_cause[1]) begin
      cause_code_next = `GIA_CODE_RX_TIMEOUT;
   end else if (uart_cause[2]) begin
      cause_code_next = `GIA_CODE_TX_READY;
   end else if (uart_cause[3]) begin
      cause_code_next = `GIA_CODE_MODEM;
   end else if (pin_pending) begin
      cause_code_next = `GIA_CODE_PINS;
   end else if (timer_pending) begin
      cause_code_next = `GIA_CODE_TIMER;
   end else begin
      // Wake-up shares the none code
      cause_code_next = `GIA_CODE_NONE;
   end
end
always @(posedge sys_clk) begin
   if (!rst_n) begin
      cause_code_reg <= `GIA_CODE_NONE;
      request_reg <= 1'b0;
   end else begin
      cause_code_reg <= cause_code_next;
      request_reg <= (|uart_cause) | wake_pending | pin_pending | timer_pending;
   end
end
endmodule // gia_cause_encoder

// >>> gia_aggregator.v
// Global interrupt aggregator: indicator byte and cause codes
`timescale 1ns/1ps
module gia_aggregator (
   // Clock and reset
   input wire sys_clk,
   input wire rst_n,
   // Host read port
   input wire rd_strobe,
   input wire [7:0] rd_addr,
   output reg [31:0] rd_data_reg,
   // Per-channel uart causes, four bits per channel
   input wire [15:0] uart_cause,
   // Sleep control
   input wire [3:0] channel_sleep,
   input wire device_wake,
   // Device-wide event pulses
   input wire timer_event,
   input wire pin_event,
   // Live word
   output wire [31:0] global_word,
   output wire wake_pending
);

`include "gia_defs.vh"

// ----------------------------------------------------------------------
// Address decode helpers
// ----------------------------------------------------------------------
// Exact byte match for clear-on-read strobes
function addr_is;
   input strobe;
   input [7:0] addr;
   input [7:0] ofs;
   begin
      addr_is = strobe && (addr == ofs);
   end
endfunction

// Every byte of the word window returns the whole word
function addr_in_word;
   input strobe;
   input [7:0] addr;
   begin
      addr_in_word = strobe && (addr >= `GIA_OFS_FLAGS) && (addr <= `GIA_OFS_CAUSE_HIGH);
   end
endfunction

// ----------------------------------------------------------------------
// Read strobes
// ----------------------------------------------------------------------
wire rd_flags;
wire rd_timer;
wire rd_pins;
wire rd_word;

// Only the byte at 0x80 clears wake, not 0x81 to 0x83
assign rd_flags = addr_is(rd_strobe, rd_addr, `GIA_OFS_FLAGS);
assign rd_timer = addr_is(rd_strobe, rd_addr, `GIA_OFS_TIMER_CMD);
assign rd_pins = addr_is(rd_strobe, rd_addr, `GIA_OFS_PIN_LEVEL);
assign rd_word = addr_in_word(rd_strobe, rd_addr);

// ----------------------------------------------------------------------
// Sleep tracking
// ----------------------------------------------------------------------
reg all_slept_reg;

always @(posedge sys_clk) begin
   if (!rst_n) begin
      all_slept_reg <= 1'b0;
   end else if (&channel_sleep) begin
      all_slept_reg <= 1'b1;
   end else if (device_wake) begin
      all_slept_reg <= 1'b0;
   end
end

// ----------------------------------------------------------------------
// Wake-up flag
// ----------------------------------------------------------------------
reg wake_reg;

always @(posedge sys_clk) begin
   if (!rst_n) begin
      wake_reg <= 1'b0;
   end else if (device_wake && all_slept_reg) begin
      wake_reg <= 1'b1;
   end else if (rd_flags) begin
      wake_reg <= 1'b0;
   end
end
assign wake_pending = wake_reg;

// ----------------------------------------------------------------------
// Timer and pin flags
// ----------------------------------------------------------------------
reg timer_reg;
reg pin_reg;

// Events are single-cycle pulses from the timer and pins
// Set wins so an event in the read cycle is kept
// timer clears on command read
always @(posedge sys_clk) begin
   if (!rst_n) begin
      timer_reg <= 1'b0;
   end else if (timer_event) begin
      timer_reg <= 1'b1;
   end else if (rd_timer) begin
      timer_reg <= 1'b0;
   end
end

// pin event clears on level read
always @(posedge sys_clk) begin
   if (!rst_n) begin
      pin_reg <= 1'b0;
   end else if (pin_event) begin
      pin_reg <= 1'b1;
   end else if (rd_pins) begin
      pin_reg <= 1'b0;
   end
end

// ----------------------------------------------------------------------
// Channel 0 encoder
// ----------------------------------------------------------------------
wire [3:0] request;
wire [2:0] code_ch0;
wire [2:0] code_ch1;
wire [2:0] code_ch2;
wire [2:0] code_ch3;

// Encoders register their outputs, one cycle of latency
// events only on channel 0
gia_cause_encoder gia_cause_encoder_ch0_i (
   .sys_clk(sys_clk),
   .rst_n(rst_n),
   .uart_cause(uart_cause[3:0]),
   .wake_pending(wake_reg),
   .pin_pending(pin_reg),
   .timer_pending(timer_reg),
   .cause_code_reg(code_ch0),
   .request_reg(request[0])
);

// ----------------------------------------------------------------------
// Channels 1 to 3, no device-wide events
// ----------------------------------------------------------------------
gia_cause_encoder gia_cause_encoder_ch1_i (
   .sys_clk(sys_clk),
   .rst_n(rst_n),
   .uart_cause(uart_cause[7:4]),
   .wake_pending(1'b0),
   .pin_pending(1'b0),
   .timer_pending(1'b0),
   .cause_code_reg(code_ch1),
   .request_reg(request[1])
);

gia_cause_encoder gia_cause_encoder_ch2_i (
   .sys_clk(sys_clk),
   .rst_n(rst_n),
   .uart_cause(uart_cause[11:8]),
   .wake_pending(1'b0),
   .pin_pending(1'b0),
   .timer_pending(1'b0),
   .cause_code_reg(code_ch2),
   .request_reg(request[2])
);

gia_cause_encoder gia_cause_encoder_ch3_i (
   .sys_clk(sys_clk),
   .rst_n(rst_n),
   .uart_cause(uart_cause[15:12]),
   .wake_pending(1'b0),
   .pin_pending(1'b0),
   .timer_pending(1'b0),
   .cause_code_reg(code_ch3),
   .request_reg(request[3])
);

// ----------------------------------------------------------------------
// Register lanes
// ----------------------------------------------------------------------
// Lanes named after the four byte registers
wire [7:0] channel_pending_flags;
wire [7:0] cause_codes_low;
wire [7:0] cause_codes_mid;
wire [7:0] cause_codes_high;

assign channel_pending_flags = {`GIA_FLAGS_RSVD, request};
// consecutive code fields
// Channel 2 code straddles the low and mid lanes
assign cause_codes_low = {code_ch2[1:0], code_ch1, code_ch0};
assign cause_codes_mid = {`GIA_MID_RSVD, code_ch3, code_ch2[2]};
assign cause_codes_high = `GIA_HIGH_RSVD;
assign global_word = {cause_codes_high, cause_codes_mid, cause_codes_low, channel_pending_flags};

// ----------------------------------------------------------------------
// Read data
// ----------------------------------------------------------------------
// Data stands one cycle, then returns to zero
// Any other address reads zero
always @(posedge sys_clk) begin
   if (!rst_n) begin
      rd_data_reg <= `GIA_WORD_ZERO;
   end else if (rd_word) begin
      rd_data_reg <= global_word;
   end else begin
      rd_data_reg <= `GIA_WORD_ZERO;
   end
end

endmodule // gia_aggregator

// >>> gia_aggregator_sva.sv
// Checker for the global interrupt aggregator
`timescale 1ns/1ps
module gia_aggregator_sva (
   input wire sys_clk, rst_n, rd_strobe, device_wake, wake_pending, input wire [7:0] rd_addr,
   input wire [15:0] uart_cause, input wire [31:0] rd_data_reg, global_word
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire hit = rd_strobe && rd_addr[7:2] == 6'h20;
   wire [31:0] gw = global_word;
   a_read_word: assert property (hit |=> rd_data_reg == $past(gw)) else $error("bad read");
   a_read_idle: assert property (!hit |=> rd_data_reg == 32'h0) else $error("idle");
   a_flags_rsvd: assert property (gw[7:4] == 4'h0) else $error("rsvd");
   a_upper_zero: assert property (gw[31:20] == 12'h0) else $error("upper");
   a_flag_ch3: assert property (1'b1 |=> gw[3] == $past(|uart_cause[15:12]))
      else $error("flag");
   a_ch1_rx: assert property (uart_cause[4] |=> gw[13:11] == 3'h1) else $error("ch1");
   a_ch3_modem: assert property (uart_cause[15:12] == 4'h8 |=> gw[19:17] == 3'h4)
      else $error("ch3");
   a_ch2_quiet: assert property (uart_cause[11:8] == 4'h0 |=> gw[16:14] == 3'h0)
      else $error("ch2");
   a_ch0_uart: assert property (uart_cause[0] |=> gw[10:8] == 3'h1) else $error("ch0");
   a_wake_clear: assert property (rd_strobe && rd_addr == 8'h80 && !device_wake |=> !wake_pending)
      else $error("wake");
   a_reset_zero: assert property (!$past(rst_n) |-> gw == 32'h0) else $error("reset");
   cover property (hit);
   cover property ($rose(wake_pending));
   cover property (gw[10:8] == 3'h6);
endmodule // gia_aggregator_sva
bind gia_aggregator gia_aggregator_sva gia_aggregator_sva_i (.*);

// >>> gia_aggregator_tb.sv
// Testbench for the global interrupt aggregator
`timescale 1ns/1ps
module gia_aggregator_tb;
   logic sys_clk = 0, rst_n = 0, rd_strobe = 0, device_wake = 0, timer_event = 0, pin_event = 0;
   logic [7:0] rd_addr = 8'h0;
   logic [15:0] uart_cause = 16'h0;
   logic [3:0] channel_sleep = 4'h0;
   wire [31:0] rd_data_reg, global_word;
   wire wake_pending;
   int errors = 0, check_count = 0;
   gia_aggregator gia_aggregator_i (.*);
   initial forever #50 sys_clk = ~sys_clk;
   task rd(input [7:0] a, input [31:0] x);
      @(negedge sys_clk) {rd_strobe, rd_addr} = {1'b1, a};
      @(negedge sys_clk) rd_strobe = 0;
      check_count++;
      if (rd_data_reg !== x) begin
         errors++;
         $display("mismatch %0t: read %h", $time, rd_data_reg);
      end
   endtask
   task ev(input [2:0] v);
      @(negedge sys_clk) {timer_event, pin_event, device_wake} = v;
      @(negedge sys_clk) {timer_event, pin_event, device_wake} = 3'h0;
   endtask
   task t_causes;
      uart_cause = 16'h842f;
      rd(8'h83, 32'h0008_d10f);
      uart_cause = 16'h0;
      rd(8'h82, 32'h0);
   endtask
   task t_events;
      uart_cause = 16'h8;
      ev(3'h4);
      rd(8'h80, 32'h401);
      uart_cause = 16'h0;
      ev(3'h2);
      rd(8'h80, 32'h601);
      rd(8'h90, 32'h0);
      rd(8'h80, 32'h701);
      rd(8'h84, 32'h0);
      rd(8'h80, 32'h0);
   endtask
   task t_wake;
      channel_sleep = 4'h7;
      ev(3'h1);
      rd(8'h80, 32'h0);
      channel_sleep = 4'hf;
      ev(3'h1);
      rd(8'h81, 32'h1);
      rd(8'h80, 32'h1);
      rd(8'h80, 32'h0);
   endtask
   task tally_and_finish;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge sys_clk);
      rst_n = 1;
      rd(8'h80, 32'h0);
      t_causes;
      t_events;
      t_wake;
      tally_and_finish;
   end
   initial begin
      #200000 errors++;
      tally_and_finish;
   end
endmodule // gia_aggregator_tb
